// [design/tos_sequencer.sv]
// turn-off sequencer top
// assumes async pins
//
// Notes on behaviour
// - delay select 000 goes with retry off.
// - delay select 111 waits seven rise times.
// - delay select bits copy bit 5.
// - delay select resets to 111.
// - a stop holds the output for the delay.
// - loop slave nacks and flags guarded commands.
// - exponent bits read zero.
// - seven low mantissa bits writable, delay resets 0.
// - only sixteen delay times exist.
// - buckets 0-6 direct, 7,10,14,19,27,37,52,72, 100 above 86.
// - after the delay the output ramps to zero.
// - fall setting 0 gives a 1 ms ramp.
// - save-all stores both settings.
// - fall resets to 3 with a 1 ms floor.
// - retry 000 stops restart, 111 restarts forever.
// - other retry values are rejected and flagged.
`timescale 1ns/1ps
`include "tos_defines.svh"
module tos_sequencer #(
    parameter int MS_CYCLES = `TOS_MS_CYCLES
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic linkClock,
    input wire logic linkReqValid,
    input wire logic linkReqWrite,
    input wire logic [7:0] linkReqCode,
    input wire logic [15:0] linkReqData,
    output logic linkReqReady,
    output logic linkRespValid,
    output logic linkRespAck,
    output logic [15:0] linkRespData,
    input wire logic loopSlavePin,
    input wire logic stopPin,
    input wire logic startupTimeoutPin,
    input wire logic [6:0] softStartRiseMs,
    output logic smbAlert,
    output logic invalidCommandFault,
    output logic commFaultSummary,
    output logic invalidDataFault,
    output logic holdingOutput,
    output logic rampingDown,
    output logic outputOff,
    output logic softStartReq,
    output logic faultLatchedOff,
    output logic nvmSave,
    output logic [6:0] nvmDelay,
    output logic [6:0] nvmRamp,
    output logic nvmRsp,
    output logic nvmRetry
);
    // mantissa to bucket time
    function automatic logic [6:0] quantize(input logic [6:0] m);
        if (m <= 7'h06) quantize = m;
        else if (m <= 7'h09) quantize = 7'h07;
        else if (m <= 7'h0C) quantize = 7'h0A;
        else if (m <= 7'h11) quantize = 7'h0E;
        else if (m <= 7'h16) quantize = 7'h13;
        else if (m <= 7'h20) quantize = 7'h1B;
        else if (m <= 7'h2C) quantize = 7'h25;
        else if (m <= 7'h3E) quantize = 7'h34;
        else if (m <= 7'h56) quantize = 7'h48;
        else quantize = 7'h64;
    endfunction

    function automatic logic guarded(input logic [7:0] code);
        guarded = (code == `TOS_CMD_FAULT_RESP) || (code == `TOS_CMD_OFF_DELAY)
            || (code == `TOS_CMD_OFF_FALL);
    endfunction

    // link side request hold
    logic linkBusy, next_linkBusy;
    logic reqTog, next_reqTog;
    logic linkWrite, next_linkWrite;
    logic [7:0] linkCode, next_linkCode;
    logic [15:0] linkData, next_linkData;
    logic ackMeta, ackSync, ackSeen;
    logic next_respValid, next_respAck;
    logic [15:0] next_respData;
    logic ackEdge;
    // answer, stable before toggle
    logic sysAck, next_sysAck;
    logic [15:0] sysRdata, next_sysRdata;
    logic ackTog, next_ackTog;

    assign ackEdge = ackSync ^ ackSeen;
    assign linkReqReady = ~linkBusy;

    always_comb begin
        next_linkBusy = linkBusy;
        next_reqTog = reqTog;
        next_linkWrite = linkWrite;
        next_linkCode = linkCode;
        next_linkData = linkData;
        next_respValid = 1'b0;
        next_respAck = linkRespAck;
        next_respData = linkRespData;
        if (!linkBusy && linkReqValid) begin
            next_linkBusy = 1'b1;
            next_reqTog = ~reqTog;
            next_linkWrite = linkReqWrite;
            next_linkCode = linkReqCode;
            next_linkData = linkReqData;
        end else if (linkBusy && ackEdge) begin
            next_linkBusy = 1'b0;
            next_respValid = 1'b1;
            next_respAck = sysAck;
            next_respData = sysRdata;
        end
    end

    always_ff @(posedge linkClock or posedge sys_rst) begin
        if (sys_rst) begin
            linkBusy <= 1'b0;
            reqTog <= 1'b0;
            linkWrite <= 1'b0;
            linkCode <= 8'h00;
            linkData <= 16'h0000;
            ackMeta <= 1'b0;
            ackSync <= 1'b0;
            ackSeen <= 1'b0;
            linkRespValid <= 1'b0;
            linkRespAck <= 1'b0;
            linkRespData <= 16'h0000;
        end else begin
            linkBusy <= next_linkBusy;
            reqTog <= next_reqTog;
            linkWrite <= next_linkWrite;
            linkCode <= next_linkCode;
            linkData <= next_linkData;
            ackMeta <= ackTog;
            ackSync <= ackMeta;
            ackSeen <= ackSync;
            linkRespValid <= next_respValid;
            linkRespAck <= next_respAck;
            linkRespData <= next_respData;
        end
    end

    // synchronisers
    logic reqMeta, reqSync, reqSeen;
    logic [2:0] pinMeta, pinSync, pinPrev;
    logic reqEdge, loopSlave, stopEdge, timeoutEdge;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            reqMeta <= 1'b0;
            reqSync <= 1'b0;
            reqSeen <= 1'b0;
            pinMeta <= 3'h0;
            pinSync <= 3'h0;
            pinPrev <= 3'h0;
        end else begin
            reqMeta <= reqTog;
            reqSync <= reqMeta;
            reqSeen <= reqSync;
            pinMeta <= {startupTimeoutPin, stopPin, loopSlavePin};
            pinSync <= pinMeta;
            pinPrev <= pinSync;
        end
    end

    assign reqEdge = reqSync ^ reqSeen;
    assign loopSlave = pinSync[0];
    assign stopEdge = pinSync[1] & ~pinPrev[1];
    assign timeoutEdge = pinSync[2] & ~pinPrev[2];

    // settings and flags
    tos_seq_if seq ();
    logic [6:0] delayMant, next_delayMant;
    logic [6:0] fallMant, next_fallMant;
    logic rspBit, next_rspBit;
    logic retryBit, next_retryBit;
    logic ivcFlag, next_ivcFlag;
    logic cmlFlag, next_cmlFlag;
    logic invDataFlag, next_invDataFlag;
    logic next_nvmSave, next_nvmRsp, next_nvmRetry;
    logic [6:0] next_nvmDelay, next_nvmRamp;
    logic clearReq, setIvc, setInv;
    logic [2:0] retryWr;
    logic [6:0] fallQ;

    assign retryWr = linkData[`TOS_RS_HI:`TOS_RS_LO];

    always_comb begin
        next_delayMant = delayMant;
        next_fallMant = fallMant;
        next_rspBit = rspBit;
        next_retryBit = retryBit;
        next_sysAck = sysAck;
        next_sysRdata = sysRdata;
        next_ackTog = ackTog;
        next_nvmSave = 1'b0;
        next_nvmDelay = nvmDelay;
        next_nvmRamp = nvmRamp;
        next_nvmRsp = nvmRsp;
        next_nvmRetry = nvmRetry;
        clearReq = 1'b0;
        setIvc = 1'b0;
        setInv = 1'b0;
        if (reqEdge) begin
            next_ackTog = ~ackTog;
            next_sysAck = 1'b1;
            next_sysRdata = 16'h0000;
            if (loopSlave && guarded(linkCode)) begin
                next_sysAck = 1'b0;
                setIvc = 1'b1;
            end else begin
                case (linkCode)
                    `TOS_CMD_FAULT_RESP: begin
                        if (linkWrite) begin
                            if (retryWr == `TOS_RETRY_OFF || retryWr == `TOS_RETRY_ON) begin
                                next_rspBit = linkData[`TOS_RSP_BIT];
                                next_retryBit = linkData[`TOS_RS_HI];
                            end else begin
                                setInv = 1'b1;
                            end
                        end else begin
                            next_sysRdata = {8'h00, rspBit, 1'b0, {6{retryBit}}};
                        end
                    end
                    `TOS_CMD_OFF_DELAY: begin
                        if (linkWrite) next_delayMant = linkData[6:0];
                        else next_sysRdata = {9'h000, delayMant};
                    end
                    `TOS_CMD_OFF_FALL: begin
                        if (linkWrite) next_fallMant = linkData[6:0];
                        else next_sysRdata = {9'h000, fallMant};
                    end
                    `TOS_CMD_STORE_ALL: begin
                        next_nvmSave = 1'b1;
                        next_nvmDelay = delayMant;
                        next_nvmRamp = fallMant;
                        next_nvmRsp = rspBit;
                        next_nvmRetry = retryBit;
                    end
                    `TOS_CMD_CLEAR_FAULTS: begin
                        clearReq = 1'b1;
                    end
                    default: begin
                        next_sysAck = 1'b0;
                        setIvc = 1'b1;
                    end
                endcase
            end
        end
        // a set in the same cycle as a clear wins
        next_ivcFlag = setIvc | (ivcFlag & ~clearReq);
        next_invDataFlag = setInv | (invDataFlag & ~clearReq);
        next_cmlFlag = setIvc | setInv | (cmlFlag & ~clearReq);
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            delayMant <= `TOS_DELAY_RST;
            fallMant <= `TOS_FALL_RST;
            rspBit <= `TOS_RSP_RST;
            retryBit <= `TOS_RETRY_RST;
            sysAck <= 1'b0;
            sysRdata <= 16'h0000;
            ackTog <= 1'b0;
            ivcFlag <= 1'b0;
            cmlFlag <= 1'b0;
            invDataFlag <= 1'b0;
            nvmSave <= 1'b0;
            nvmDelay <= `TOS_DELAY_RST;
            nvmRamp <= `TOS_FALL_RST;
            nvmRsp <= `TOS_RSP_RST;
            nvmRetry <= `TOS_RETRY_RST;
        end else begin
            delayMant <= next_delayMant;
            fallMant <= next_fallMant;
            rspBit <= next_rspBit;
            retryBit <= next_retryBit;
            sysAck <= next_sysAck;
            sysRdata <= next_sysRdata;
            ackTog <= next_ackTog;
            ivcFlag <= next_ivcFlag;
            cmlFlag <= next_cmlFlag;
            invDataFlag <= next_invDataFlag;
            nvmSave <= next_nvmSave;
            nvmDelay <= next_nvmDelay;
            nvmRamp <= next_nvmRamp;
            nvmRsp <= next_nvmRsp;
            nvmRetry <= next_nvmRetry;
        end
    end

    assign invalidCommandFault = ivcFlag;
    assign commFaultSummary = cmlFlag;
    assign invalidDataFault = invDataFlag;
    assign smbAlert = ivcFlag | cmlFlag | invDataFlag;

    // shutdown sequence
    assign fallQ = quantize(fallMant);
    assign seq.start = stopEdge;
    assign seq.delayMs = quantize(delayMant);
    assign seq.fallMs = (fallQ < `TOS_MIN_FALL) ? `TOS_MIN_FALL : fallQ;

    tos_off_timer #(
        .MS_CYCLES(MS_CYCLES)
    ) u_timer (
        .clock(clock),
        .sys_rst(sys_rst),
        .seq(seq)
    );

    assign holdingOutput = seq.holding;
    assign rampingDown = seq.ramping;

    // timeout restart
    tos_pkg::tos_restart_t rstState, next_rstState;
    logic [9:0] waitMs, next_waitMs;
    logic next_softStart, next_outputOff;

    always_comb begin
        next_rstState = rstState;
        next_waitMs = waitMs;
        next_softStart = 1'b0;
        next_outputOff = outputOff;
        if (seq.done) next_outputOff = 1'b1;
        case (rstState)
            tos_pkg::RST_RUN: begin
                if (timeoutEdge && rspBit) begin
                    next_outputOff = 1'b1;
                    if (retryBit) begin
                        next_rstState = tos_pkg::RST_WAIT;
                        next_waitMs = 10'(`TOS_RESTART_MULT * {3'h0, softStartRiseMs});
                    end else begin
                        next_rstState = tos_pkg::RST_OFF;
                    end
                end
            end
            tos_pkg::RST_WAIT: begin
                if (waitMs == 10'h000) begin
                    next_rstState = tos_pkg::RST_RUN;
                    next_softStart = 1'b1;
                    next_outputOff = 1'b0;
                end else if (seq.msTick) begin
                    next_waitMs = waitMs - 10'h001;
                end
            end
            tos_pkg::RST_OFF: begin
                if (clearReq) next_rstState = tos_pkg::RST_RUN;
            end
            default: begin
                next_rstState = tos_pkg::RST_RUN;
            end
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rstState <= tos_pkg::RST_RUN;
            waitMs <= 10'h000;
            softStartReq <= 1'b0;
            outputOff <= 1'b0;
        end else begin
            rstState <= next_rstState;
            waitMs <= next_waitMs;
            softStartReq <= next_softStart;
            outputOff <= next_outputOff;
        end
    end

    assign faultLatchedOff = (rstState == tos_pkg::RST_OFF);
endmodule

// [design/tos_defines.svh]
// sequencer constants: codes, resets, fields, timing
// assumes inclusion by bare name
`ifndef TOS_DEFINES_SVH
`define TOS_DEFINES_SVH

`define TOS_CMD_CLEAR_FAULTS 8'h03
`define TOS_CMD_STORE_ALL 8'h11
`define TOS_CMD_FAULT_RESP 8'h63
`define TOS_CMD_OFF_DELAY 8'h64
`define TOS_CMD_OFF_FALL 8'h65

`define TOS_MANT_W 7
`define TOS_DELAY_RST 7'h00
`define TOS_FALL_RST 7'h03
`define TOS_RSP_RST 1'b1
`define TOS_RETRY_RST 1'b1
`define TOS_MIN_FALL 7'h01

`define TOS_RSP_BIT 7
`define TOS_RS_HI 5
`define TOS_RS_LO 3
`define TOS_RETRY_OFF 3'h0
`define TOS_RETRY_ON 3'h7
`define TOS_RESTART_MULT 10'h007

`define TOS_MS_NS 1000000
`define TOS_CLK_NS 20
`define TOS_MS_CYCLES (`TOS_MS_NS / `TOS_CLK_NS)

`endif

// [design/tos_pkg.sv]
// sequencer state types
// assumes no other file
package tos_pkg;

    typedef enum logic [2:0] {
        SEQ_IDLE = 3'h1,
        SEQ_HOLD = 3'h2,
        SEQ_RAMP = 3'h4
    } tos_seq_t;

    typedef enum logic [2:0] {
        RST_RUN = 3'h1,
        RST_WAIT = 3'h2,
        RST_OFF = 3'h4
    } tos_restart_t;

endpackage

// [design/tos_seq_if.sv]
// control to timer link
// assumes one clock
`timescale 1ns/1ps
interface tos_seq_if;
    logic start, msTick, holding, ramping, done;
    logic [6:0] delayMs, fallMs;

    modport ctrl (output start, delayMs, fallMs, input msTick, holding, ramping, done);
    modport timer (input start, delayMs, fallMs, output msTick, holding, ramping, done);
endinterface

// [design/tos_off_timer.sv]
// hold then ramp timer
// assumes a one-cycle start
`timescale 1ns/1ps
`include "tos_defines.svh"
module tos_off_timer #(
    parameter int MS_CYCLES = `TOS_MS_CYCLES
) (
    input wire logic clock,
    input wire logic sys_rst,
    tos_seq_if.timer seq
);
    tos_pkg::tos_seq_t state, next_state;
    logic [31:0] presc, next_presc;
    logic [6:0] remain, next_remain;
    logic [6:0] fallHeld, next_fallHeld;
    logic done, next_done;
    logic tick;
    logic launch;

    assign launch = (state == tos_pkg::SEQ_IDLE) && seq.start;
    assign tick = (presc == 32'(MS_CYCLES - 1));

    always_comb begin
        next_presc = (tick || launch) ? 32'h0 : presc + 32'h1;
        next_state = state;
        next_remain = remain;
        next_fallHeld = fallHeld;
        next_done = 1'b0;
        case (state)
            tos_pkg::SEQ_IDLE: begin
                if (seq.start) begin
                    next_fallHeld = seq.fallMs;
                    if (seq.delayMs == 7'h00) begin
                        next_state = tos_pkg::SEQ_RAMP;
                        next_remain = seq.fallMs;
                    end else begin
                        next_state = tos_pkg::SEQ_HOLD;
                        next_remain = seq.delayMs;
                    end
                end
            end
            tos_pkg::SEQ_HOLD: begin
                if (tick) begin
                    if (remain == 7'h01) begin
                        next_state = tos_pkg::SEQ_RAMP;
                        next_remain = fallHeld;
                    end else begin
                        next_remain = remain - 7'h01;
                    end
                end
            end
            tos_pkg::SEQ_RAMP: begin
                if (tick) begin
                    if (remain == 7'h01) begin
                        next_state = tos_pkg::SEQ_IDLE;
                        next_done = 1'b1;
                    end else begin
                        next_remain = remain - 7'h01;
                    end
                end
            end
            default: begin
                next_state = tos_pkg::SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state <= tos_pkg::SEQ_IDLE;
            presc <= 32'h0;
            remain <= 7'h00;
            fallHeld <= 7'h00;
            done <= 1'b0;
        end else begin
            state <= next_state;
            presc <= next_presc;
            remain <= next_remain;
            fallHeld <= next_fallHeld;
            done <= next_done;
        end
    end

    assign seq.msTick = tick;
    assign seq.holding = (state == tos_pkg::SEQ_HOLD);
    assign seq.ramping = (state == tos_pkg::SEQ_RAMP);
    assign seq.done = done;
endmodule

// [sim/tos_monitor.sv]
// top port checker
// assumes bind onto tos_sequencer
`timescale 1ns/1ps
module tos_monitor #(
    parameter int MS_CYCLES = 20
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic linkClock,
    input wire logic linkReqValid,
    input wire logic linkReqWrite,
    input wire logic [7:0] linkReqCode,
    input wire logic linkReqReady,
    input wire logic linkRespValid,
    input wire logic linkRespAck,
    input wire logic [15:0] linkRespData,
    input wire logic loopSlavePin,
    input wire logic holdingOutput,
    input wire logic rampingDown,
    input wire logic outputOff,
    input wire logic softStartReq,
    input wire logic faultLatchedOff
);
    int holdCnt, rampCnt;
    logic [7:0] lastCode;
    logic lastRead;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            holdCnt <= 0;
            rampCnt <= 0;
        end else begin
            holdCnt <= holdingOutput ? holdCnt + 1 : 0;
            rampCnt <= rampingDown ? rampCnt + 1 : 0;
        end
    end
    always_ff @(posedge linkClock or posedge sys_rst) begin
        if (sys_rst) begin
            lastCode <= 8'h00;
            lastRead <= 1'h0;
        end else if (linkReqValid && linkReqReady) begin
            lastCode <= linkReqCode;
            lastRead <= !linkReqWrite;
        end
    end
    a_hold_then_ramp: assert property (@(posedge clock) disable iff (sys_rst)
        $fell(holdingOutput) |-> rampingDown) else $error("no ramp after hold");
    a_hold_whole_ms: assert property (@(posedge clock) disable iff (sys_rst)
        $fell(holdingOutput) |-> holdCnt % MS_CYCLES == 0) else $error("hold not whole ms");
    a_ramp_min_ms: assert property (@(posedge clock) disable iff (sys_rst)
        $fell(rampingDown) |-> rampCnt >= MS_CYCLES && rampCnt % MS_CYCLES == 0)
        else $error("ramp length wrong");
    a_loop_nack: assert property (@(posedge linkClock) disable iff (sys_rst)
        linkReqValid && linkReqReady && loopSlavePin && linkReqCode inside {8'h63, 8'h64, 8'h65}
        |-> ##[1:12] (linkRespValid && !linkRespAck)) else $error("loop access acked");
    a_delay_sel_mirror: assert property (@(posedge linkClock) disable iff (sys_rst)
        linkRespValid && linkRespAck && lastRead && lastCode == 8'h63
        |-> linkRespData[2:0] == {3{linkRespData[5]}}) else $error("select not mirrored");
    a_mant_upper_zero: assert property (@(posedge linkClock) disable iff (sys_rst)
        linkRespValid && linkRespAck && lastRead && lastCode inside {8'h64, 8'h65}
        |-> linkRespData[15:7] == 9'h000) else $error("fixed bits set");
    a_latched_no_restart: assert property (@(posedge clock) disable iff (sys_rst)
        faultLatchedOff |-> !softStartReq) else $error("restart when latched");
    a_restart_output_on: assert property (@(posedge clock) disable iff (sys_rst)
        softStartReq |-> ##[0:1] !outputOff) else $error("off at restart");
endmodule

bind tos_sequencer tos_monitor #(.MS_CYCLES(MS_CYCLES)) tos_monitor_i (.clock, .sys_rst,
    .linkClock, .linkReqValid, .linkReqWrite, .linkReqCode, .linkReqReady, .linkRespValid,
    .linkRespAck, .linkRespData, .loopSlavePin, .holdingOutput, .rampingDown, .outputOff,
    .softStartReq, .faultLatchedOff);

// [sim/tos_host_model.sv]
// host model, link clock
// assumes one request at a time
`timescale 1ns/1ps
module tos_host_model (
    input wire logic linkClock,
    input wire logic linkReqReady,
    input wire logic linkRespValid,
    input wire logic linkRespAck,
    input wire logic [15:0] linkRespData,
    output logic linkReqValid,
    output logic linkReqWrite,
    output logic [7:0] linkReqCode,
    output logic [15:0] linkReqData
);
    initial begin
        linkReqValid = 1'h0;
        linkReqWrite = 1'h0;
        linkReqCode = 8'h00;
        linkReqData = 16'h0000;
    end
    task automatic xfer(input logic w, input logic [7:0] code, input logic [15:0] data,
            output logic ack, output logic [15:0] rd, output logic tmo);
        int n;
        tmo = 1'h1;
        @(posedge linkClock);
        linkReqValid <= 1'h1;
        linkReqWrite <= w;
        linkReqCode <= code;
        linkReqData <= data;
        for (n = 0; n < 20; n++) begin
            @(posedge linkClock);
            if (linkReqReady === 1'h1) break;
        end
        linkReqValid <= 1'h0;
        linkReqWrite <= ~w;
        linkReqCode <= ~code;
        linkReqData <= ~data;
        for (n = 0; n < 20; n++) begin
            @(posedge linkClock);
            if (linkRespValid === 1'h1) begin
                ack = linkRespAck;
                rd = linkRespData;
                tmo = 1'h0;
                break;
            end
        end
    endtask
endmodule

// [sim/testbench.sv]
// sequencer bench
// assumes MS_CYCLES cut to 20
`timescale 1ns/1ps
module testbench;
    localparam int MS = 20;
    logic clock, sys_rst, linkClock, loopSlavePin, stopPin, startupTimeoutPin;
    logic linkReqValid, linkReqWrite, linkReqReady, linkRespValid, linkRespAck, smbAlert;
    logic invalidCommandFault, commFaultSummary, invalidDataFault, holdingOutput, rampingDown;
    logic outputOff, softStartReq, faultLatchedOff, nvmSave, nvmRsp, nvmRetry;
    logic [7:0] linkReqCode;
    logic [15:0] linkReqData, linkRespData;
    logic [6:0] softStartRiseMs, nvmDelay, nvmRamp;
    int err_count = 0;
    int checks = 0;
    tos_sequencer #(.MS_CYCLES(MS)) tos_sequencer_i (.clock, .sys_rst, .linkClock, .linkReqValid,
        .linkReqWrite, .linkReqCode, .linkReqData, .linkReqReady, .linkRespValid, .linkRespAck,
        .linkRespData, .loopSlavePin, .stopPin, .startupTimeoutPin, .softStartRiseMs, .smbAlert,
        .invalidCommandFault, .commFaultSummary, .invalidDataFault, .holdingOutput, .rampingDown,
        .outputOff, .softStartReq, .faultLatchedOff, .nvmSave, .nvmDelay, .nvmRamp, .nvmRsp,
        .nvmRetry);
    tos_host_model tos_host_model_i (.linkClock, .linkReqReady, .linkRespValid, .linkRespAck,
        .linkRespData, .linkReqValid, .linkReqWrite, .linkReqCode, .linkReqData);
    initial begin
        clock = 1'h0;
        forever #10 clock = ~clock;
    end
    initial begin
        linkClock = 1'h0;
        #7;
        forever #16 linkClock = ~linkClock;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic xf(input logic w, input logic [7:0] code, input logic [15:0] data,
            input logic expAck, input logic [15:0] expRd);
        logic ack;
        logic tmo;
        logic [15:0] rd;
        tos_host_model_i.xfer(w, code, data, ack, rd, tmo);
        if (tmo !== 1'h0) begin
            err_count++;
            print_verdict();
        end else begin
            chk(16'(ack), 16'(expAck));
            if (!w && expAck) chk(rd, expRd);
        end
    endtask
    task automatic measure(output int h, output int r);
        int n;
        h = 0;
        r = 0;
        for (n = 0; n < 20 && holdingOutput !== 1'h1 && rampingDown !== 1'h1; n++) @(negedge clock);
        while (holdingOutput === 1'h1 && h < 3000) begin
            @(negedge clock);
            h++;
        end
        while (rampingDown === 1'h1 && r < 3000) begin
            @(negedge clock);
            r++;
        end
        @(negedge clock);
        chk(16'(outputOff), 16'h0001);
    endtask
    task automatic t_regs;
        xf(1'h0, 8'h64, 16'h0000, 1'h1, 16'h0000);
        xf(1'h0, 8'h65, 16'h0000, 1'h1, 16'h0003);
        xf(1'h0, 8'h63, 16'h0000, 1'h1, 16'h00BF);
        xf(1'h1, 8'h64, 16'hFFFF, 1'h1, 16'h0000);
        xf(1'h0, 8'h64, 16'h0000, 1'h1, 16'h007F);
        $display("regs done");
    endtask
    task automatic t_loop;
        @(posedge clock) loopSlavePin <= 1'h1;
        repeat (10) @(posedge clock);
        xf(1'h1, 8'h64, 16'h0005, 1'h0, 16'h0000);
        xf(1'h0, 8'h65, 16'h0000, 1'h0, 16'h0000);
        xf(1'h1, 8'h63, 16'h0080, 1'h0, 16'h0000);
        @(negedge clock);
        chk({14'h0000, invalidCommandFault, smbAlert}, 16'h0003);
        @(posedge clock) loopSlavePin <= 1'h0;
        repeat (10) @(posedge clock);
        xf(1'h0, 8'h64, 16'h0000, 1'h1, 16'h007F);
        xf(1'h1, 8'h03, 16'h0000, 1'h1, 16'h0000);
        $display("loop done");
    endtask
    task automatic t_stop;
        int h, r, i;
        logic [6:0] m [11] = '{7'h00, 7'h06, 7'h09, 7'h0A, 7'h11, 7'h16, 7'h20, 7'h2C, 7'h3E,
            7'h56, 7'h57};
        int e [11] = '{0, 6, 7, 10, 14, 19, 27, 37, 52, 72, 100};
        for (i = 0; i < 11; i++) begin
            xf(1'h1, 8'h64, {9'h000, m[i]}, 1'h1, 16'h0000);
            xf(1'h1, 8'h65, {9'h000, m[i]}, 1'h1, 16'h0000);
            @(posedge clock) stopPin <= 1'h1;
            measure(h, r);
            chk(16'(h), 16'(e[i] * MS));
            chk(16'(r), 16'((e[i] == 0 ? 1 : e[i]) * MS));
            @(posedge clock) stopPin <= 1'h0;
        end
        xf(1'h1, 8'h64, 16'h0005, 1'h1, 16'h0000);
        xf(1'h1, 8'h65, 16'h0000, 1'h1, 16'h0000);
        @(posedge clock) stopPin <= 1'h1;
        fork
            measure(h, r);
            xf(1'h1, 8'h64, 16'h0001, 1'h1, 16'h0000);
        join
        chk(16'(h), 16'(5 * MS));
        @(posedge clock) stopPin <= 1'h0;
        $display("stop done");
    endtask
    task automatic t_save;
        xf(1'h1, 8'h11, 16'h0000, 1'h1, 16'h0000);
        @(negedge clock);
        chk({7'h00, nvmDelay, nvmRsp, nvmRetry}, 16'h0007);
        chk(16'(nvmRamp), 16'h0000);
        $display("save done");
    endtask
    task automatic t_fault;
        int n;
        xf(1'h1, 8'h63, 16'h0090, 1'h1, 16'h0000);
        xf(1'h0, 8'h63, 16'h0000, 1'h1, 16'h00BF);
        @(negedge clock);
        chk({13'h0000, invalidDataFault, commFaultSummary, smbAlert}, 16'h0007);
        xf(1'h1, 8'h7E, 16'h0000, 1'h0, 16'h0000);
        xf(1'h1, 8'h03, 16'h0000, 1'h1, 16'h0000);
        xf(1'h1, 8'h63, 16'h0080, 1'h1, 16'h0000);
        xf(1'h0, 8'h63, 16'h0000, 1'h1, 16'h0080);
        @(posedge clock) startupTimeoutPin <= 1'h1;
        repeat (10) @(negedge clock);
        chk({13'h0000, smbAlert, faultLatchedOff, outputOff}, 16'h0003);
        @(posedge clock) startupTimeoutPin <= 1'h0;
        xf(1'h1, 8'h03, 16'h0000, 1'h1, 16'h0000);
        @(negedge clock);
        chk(16'(faultLatchedOff), 16'h0000);
        xf(1'h1, 8'h63, 16'h00B8, 1'h1, 16'h0000);
        xf(1'h0, 8'h63, 16'h0000, 1'h1, 16'h00BF);
        @(posedge clock) startupTimeoutPin <= 1'h1;
        for (n = 0; n < 400 && softStartReq !== 1'h1; n++) @(negedge clock);
        chk(16'(n >= 255 && n <= 290), 16'h0001);
        repeat (2) @(negedge clock);
        chk(16'(outputOff), 16'h0000);
        @(posedge clock) startupTimeoutPin <= 1'h0;
        $display("fault done");
    endtask
    initial begin
        sys_rst = 1'h1;
        loopSlavePin = 1'h0;
        stopPin = 1'h0;
        startupTimeoutPin = 1'h0;
        softStartRiseMs = 7'h02;
        repeat (16) @(posedge clock);
        sys_rst <= 1'h0;
        t_regs();
        t_loop();
        t_stop();
        t_save();
        t_fault();
        print_verdict();
    end
endmodule
